// File: afc_lpi_pkg.sv
// shared constants for the auto flow control and lpi statistics block
package afc_lpi_pkg;
   // system register byte offsets
   localparam logic [7:0] OFS_IND_CMD = 8'ha0;
   localparam logic [7:0] OFS_IND_VAL = 8'ha4;
   localparam logic [7:0] OFS_AUTO_FLOW_CONFIG = 8'hac;
   localparam logic [7:0] OFS_RX_LPI_CNT = 8'hb0;
   localparam logic [7:0] OFS_RX_LPI_TIME = 8'hb4;
   localparam logic [7:0] OFS_TX_LPI_CNT = 8'hb8;
   localparam logic [7:0] OFS_TX_LPI_TIME = 8'hbc;
   // indirect mac register indices
   localparam logic [7:0] IDX_MAC_CTRL = 8'h01;
   localparam logic [7:0] IDX_PHY_ACC = 8'h06;
   localparam logic [7:0] IDX_PHY_VAL = 8'h07;
   localparam logic [7:0] IDX_FLOW = 8'h08;
   // indirect command fields
   localparam int CMD_BUSY_BIT = 31;
   localparam int CMD_RNW_BIT = 30;
   // auto flow config fields
   localparam int CFG_HI_LSB = 16;
   localparam int CFG_LO_LSB = 8;
   localparam int CFG_DUR_LSB = 4;
   localparam int CFG_MCAST_BIT = 3;
   localparam int CFG_BCAST_BIT = 2;
   localparam int CFG_OWN_BIT = 1;
   localparam int CFG_ANY_BIT = 0;
   localparam logic [31:0] CFG_USED_MASK = 32'h00ffffff;
   // mac control fields
   localparam int CTRL_EEE_BIT = 25;
   localparam int CTRL_FDPX_BIT = 20;
   localparam int CTRL_TXEN_BIT = 3;
   localparam logic [31:0] CTRL_RESET = 32'h00040000;
   // phy management access fields
   localparam int ACC_BUSY_BIT = 0;
   localparam int ACC_WRITE_BIT = 1;
   localparam int FLOW_TIME_LSB = 16;
   // threshold granularity in bytes, as a shift
   localparam int THR_SHIFT = 6;
   localparam int LEVEL_W = 14;
   // timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int US_NS = 1000;
   localparam int CYCLES_PER_US = US_NS / CLK_PERIOD_NS;
   localparam int EXTRA_10M_NS = 2200;
   localparam int TIMER_W = 20;
endpackage

// File: afc_lpi.sv
// automatic receive flow control trigger with eee lpi statistics
`timescale 1ns/1ns

module afc_lpi #(
   parameter int US_CYCLES = afc_lpi_pkg::CYCLES_PER_US
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // system register port
   input wire logic [7:0] csr_addr,
   input wire logic csr_wr,
   input wire logic csr_rd,
   input wire logic [31:0] csr_wdata,
   output logic [31:0] csr_rdata,
   // receive path status
   input wire logic [afc_lpi_pkg::LEVEL_W-1:0] rx_fifo_level,
   input wire logic rx_preamble,
   input wire logic rx_da_valid,
   input wire logic rx_da_bcast,
   input wire logic rx_da_mcast,
   input wire logic rx_da_own,
   input wire logic link_100m,
   // flow control actions
   output logic jam_active,
   output logic pause_req,
   output logic pause_zero_req,
   input wire logic pause_ack,
   output logic [15:0] pause_time,
   // lpi signals
   input wire logic rx_lpi_pin,
   input wire logic tx_lpi_req,
   // phy management engine
   output logic mgmt_start,
   output logic [31:0] mgmt_access,
   output logic [15:0] mgmt_wdata,
   input wire logic mgmt_done,
   input wire logic [15:0] mgmt_rdata,
   // mode outputs
   output logic full_duplex,
   output logic eee_enable
);
   import afc_lpi_pkg::*;

   // duration code to cycles; 10m adds a fixed pad
   function automatic logic [TIMER_W-1:0] dur_cycles(input logic [3:0] code,
                                                     input logic fast);
      int us;
      int cyc;
      case (code)
         4'h0: us = 5;
         4'h1: us = 10;
         4'h2: us = 15;
         4'h3: us = 25;
         4'h4: us = 50;
         default: us = (int'(code) - 3) * 50;
      endcase
      cyc = us * US_CYCLES;
      if (!fast)
         cyc = cyc + (EXTRA_10M_NS * US_CYCLES) / US_NS;
      return cyc[TIMER_W-1:0];
   endfunction

   // registers
   logic [31:0] cfg_r; // auto_flow_config
   logic [31:0] ind_cmd_r; // indirect_command
   logic [31:0] ind_val_r; // indirect_value
   logic [31:0] ctrl_r; // mac_control
   logic [31:0] flow_r; // mac_flow_control
   logic [31:0] phy_acc_r; // phy_mgmt_access
   logic [31:0] phy_val_r; // phy_mgmt_value
   logic [31:0] rx_cnt_r; // rx_lpi_entry_count
   logic [31:0] rx_time_r; // rx_lpi_total_time
   logic [31:0] tx_cnt_r; // tx_lpi_entry_count
   logic [31:0] tx_time_r; // tx_lpi_total_time
   logic [31:0] rdata_r;
   logic [31:0] ind_rd;
   logic ind_wr;

   // flow control state
   logic above_hi;
   logic below_lo;
   logic above_hi_r;
   logic hi_reach;
   logic tx_on;
   logic any_en;
   logic class_en;
   logic [TIMER_W-1:0] bp_timer_r;
   logic jam_r;
   logic pause_r;
   logic zero_r;
   logic pause_sent_r;
   logic class_hit;

   // lpi state
   logic rx_lpi_s1_r;
   logic rx_lpi_s2_r;
   logic rx_lpi_d_r;
   logic tx_lpi_d_r;
   logic [TIMER_W-1:0] us_cnt_r;
   logic us_tick;

   assign eee_enable = ctrl_r[CTRL_EEE_BIT];
   assign full_duplex = ctrl_r[CTRL_FDPX_BIT];
   assign tx_on = ctrl_r[CTRL_TXEN_BIT];
   assign pause_time = flow_r[31:FLOW_TIME_LSB];
   assign csr_rdata = rdata_r;
   assign jam_active = jam_r;
   assign pause_req = pause_r;
   assign pause_zero_req = zero_r;
   assign mgmt_access = phy_acc_r;
   assign mgmt_wdata = phy_val_r[15:0];

   // indirect write fires when busy is written as one with the read bit clear
   assign ind_wr = ind_cmd_r[CMD_BUSY_BIT] && !ind_cmd_r[CMD_RNW_BIT];

   // indirect readback; reserved and absent indices read zero
   always_comb
   begin
      case (ind_cmd_r[7:0])
         IDX_MAC_CTRL: ind_rd = ctrl_r;
         IDX_PHY_ACC: ind_rd = phy_acc_r;
         IDX_PHY_VAL: ind_rd = phy_val_r;
         IDX_FLOW: ind_rd = flow_r;
         default: ind_rd = 32'h00000000;
      endcase
   end

   // command register; busy holds one cycle while the move happens
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         ind_cmd_r <= 32'h00000000;
      else if (csr_wr && csr_addr == OFS_IND_CMD)
         ind_cmd_r <= csr_wdata;
      else
         ind_cmd_r[CMD_BUSY_BIT] <= 1'b0;
   end

   // value register; a finished read fetches the indexed register
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         ind_val_r <= 32'h00000000;
      else if (ind_cmd_r[CMD_BUSY_BIT] && ind_cmd_r[CMD_RNW_BIT])
         ind_val_r <= ind_rd;
      else if (csr_wr && csr_addr == OFS_IND_VAL)
         ind_val_r <= csr_wdata;
   end

   // indirect mac registers written from the value register
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         ctrl_r <= CTRL_RESET;
         flow_r <= 32'h00000000;
      end
      else if (ind_wr)
      begin
         if (ind_cmd_r[7:0] == IDX_MAC_CTRL)
            ctrl_r <= ind_val_r;
         if (ind_cmd_r[7:0] == IDX_FLOW)
            flow_r <= ind_val_r;
      end
   end

   // phy access; busy set by software, cleared by engine, set wins
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         phy_acc_r <= 32'h00000000;
      else if (ind_wr && ind_cmd_r[7:0] == IDX_PHY_ACC)
         phy_acc_r <= ind_val_r;
      else if (mgmt_done)
         phy_acc_r[ACC_BUSY_BIT] <= 1'b0;
   end

   // phy data; engine read result lands here
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         phy_val_r <= 32'h00000000;
      else if (ind_wr && ind_cmd_r[7:0] == IDX_PHY_VAL)
         phy_val_r <= ind_val_r;
      else if (mgmt_done && !phy_acc_r[ACC_WRITE_BIT])
         phy_val_r <= {16'h0000, mgmt_rdata};
   end

   // start pulse when an access with busy is posted
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         mgmt_start <= 1'b0;
      else
         mgmt_start <= ind_wr && ind_cmd_r[7:0] == IDX_PHY_ACC && ind_val_r[ACC_BUSY_BIT];
   end

   // flow config; reserved top byte stays zero
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         cfg_r <= 32'h00000000;
      else if (csr_wr && csr_addr == OFS_AUTO_FLOW_CONFIG)
         cfg_r <= csr_wdata & CFG_USED_MASK;
   end

   // read data registered, unmapped offsets answer zero
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         rdata_r <= 32'h00000000;
      else if (csr_rd)
      begin
         case (csr_addr)
            OFS_IND_CMD: rdata_r <= ind_cmd_r;
            OFS_IND_VAL: rdata_r <= ind_val_r;
            OFS_AUTO_FLOW_CONFIG: rdata_r <= cfg_r;
            OFS_RX_LPI_CNT: rdata_r <= rx_cnt_r;
            OFS_RX_LPI_TIME: rdata_r <= rx_time_r;
            OFS_TX_LPI_CNT: rdata_r <= tx_cnt_r;
            OFS_TX_LPI_TIME: rdata_r <= tx_time_r;
            default: rdata_r <= 32'h00000000;
         endcase
      end
   end

   // level compare in 64 byte units
   assign above_hi = rx_fifo_level >= {cfg_r[CFG_HI_LSB +: 8], 6'h00};
   assign below_lo = rx_fifo_level < {cfg_r[CFG_LO_LSB +: 8], 6'h00};
   assign hi_reach = above_hi && !above_hi_r;
   assign any_en = cfg_r[CFG_ANY_BIT];
   // class enables only in half duplex and only without any-frame
   assign class_en = !full_duplex && !any_en;
   assign class_hit = rx_da_valid && class_en &&
                      ((cfg_r[CFG_BCAST_BIT] && rx_da_bcast) ||
                       (cfg_r[CFG_OWN_BIT] && rx_da_own) ||
                       (cfg_r[CFG_MCAST_BIT] && rx_da_mcast));

   // edge memory of the high level
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         above_hi_r <= 1'b0;
      else
         above_hi_r <= above_hi;
   end

   // backpressure window starts at the level crossing, not the jam
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         bp_timer_r <= '0;
      else if (hi_reach && !full_duplex && tx_on && cfg_r[3:0] != 4'h0)
         bp_timer_r <= dur_cycles(cfg_r[CFG_DUR_LSB +: 4], link_100m);
      else if (bp_timer_r != '0)
         bp_timer_r <= bp_timer_r - 1'b1;
   end

   // jam on a matching frame inside the window
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         jam_r <= 1'b0;
      else if (!tx_on || full_duplex || bp_timer_r == '0)
         jam_r <= 1'b0;
      else if ((any_en && rx_preamble) || class_hit)
         jam_r <= 1'b1;
   end

   // pause request held until the transmitter takes it
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         pause_r <= 1'b0;
      else if (!tx_on)
         pause_r <= 1'b0;
      else if (hi_reach && full_duplex && any_en)
         pause_r <= 1'b1;
      else if (pause_ack)
         pause_r <= 1'b0;
   end

   // remembers that a pause went out at the high level
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         pause_sent_r <= 1'b0;
      else if (hi_reach && full_duplex && any_en && tx_on)
         pause_sent_r <= 1'b1;
      else if (zero_r && pause_ack)
         pause_sent_r <= 1'b0;
   end

   // zero time pause once the level drains below low
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         zero_r <= 1'b0;
      else if (!tx_on)
         zero_r <= 1'b0;
      else if (pause_sent_r && !pause_r && below_lo && any_en && !zero_r)
         zero_r <= 1'b1;
      else if (pause_ack)
         zero_r <= 1'b0;
   end

   // rx lpi pin from the phy is asynchronous, two flops first
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         rx_lpi_s1_r <= 1'b0;
         rx_lpi_s2_r <= 1'b0;
         rx_lpi_d_r <= 1'b0;
         tx_lpi_d_r <= 1'b0;
      end
      else
      begin
         rx_lpi_s1_r <= rx_lpi_pin;
         rx_lpi_s2_r <= rx_lpi_s1_r;
         rx_lpi_d_r <= rx_lpi_s2_r;
         tx_lpi_d_r <= tx_lpi_req;
      end
   end

   // microsecond prescaler; free running so time is not lost
   assign us_tick = us_cnt_r == TIMER_W'(US_CYCLES - 1);
   always_ff @(posedge ref_clk)
   begin
      if (!nrst || us_tick)
         us_cnt_r <= '0;
      else
         us_cnt_r <= us_cnt_r + 1'b1;
   end

   // entry counters; wrap silently at the top
   always_ff @(posedge ref_clk)
   begin
      if (!nrst || !eee_enable)
      begin
         rx_cnt_r <= 32'h00000000;
         tx_cnt_r <= 32'h00000000;
      end
      else
      begin
         if (rx_lpi_s2_r && !rx_lpi_d_r)
            rx_cnt_r <= rx_cnt_r + 1'b1;
         if (tx_lpi_req && !tx_lpi_d_r)
            tx_cnt_r <= tx_cnt_r + 1'b1;
      end
   end

   // time counters; resolution is one tick, partial us may be lost
   always_ff @(posedge ref_clk)
   begin
      if (!nrst || !eee_enable)
      begin
         rx_time_r <= 32'h00000000;
         tx_time_r <= 32'h00000000;
      end
      else if (us_tick)
      begin
         if (rx_lpi_s2_r)
            rx_time_r <= rx_time_r + 1'b1;
         if (tx_lpi_req)
            tx_time_r <= tx_time_r + 1'b1;
      end
   end

   // checks
   sequence s_pause_set;
      hi_reach && full_duplex && any_en && tx_on;
   endsequence

   a_bcast_jam: assert property (@(posedge ref_clk) disable iff (!nrst)
      rx_da_valid && rx_da_bcast && cfg_r[CFG_BCAST_BIT] && class_en && tx_on &&
      bp_timer_r > TIMER_W'(1) |=> jam_r)
      else $error("broadcast frame not jammed");
   a_own_jam: assert property (@(posedge ref_clk) disable iff (!nrst)
      rx_da_valid && rx_da_own && cfg_r[CFG_OWN_BIT] && class_en && tx_on &&
      bp_timer_r > TIMER_W'(1) |=> jam_r)
      else $error("own address frame not jammed");
   a_fdx_no_jam: assert property (@(posedge ref_clk) disable iff (!nrst)
      full_duplex |=> !jam_r)
      else $error("jam in full duplex");
   a_any_preamble: assert property (@(posedge ref_clk) disable iff (!nrst)
      rx_preamble && any_en && !full_duplex && tx_on && bp_timer_r > TIMER_W'(1)
      |=> jam_r)
      else $error("preamble not jammed");
   a_pause_req: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_pause_set |=> pause_r)
      else $error("pause not requested");
   a_override: assert property (@(posedge ref_clk) disable iff (!nrst)
      any_en && !rx_preamble && !jam_r |=> !jam_r)
      else $error("class enable acted with any-frame set");
   a_timer_load: assert property (@(posedge ref_clk) disable iff (!nrst)
      hi_reach && !full_duplex && tx_on && cfg_r[3:0] != 4'h0 && cfg_r[7:4] == 4'h0
      && link_100m |=> bp_timer_r == TIMER_W'(5 * US_CYCLES))
      else $error("timer not loaded at level crossing");
   a_rx_entry: assert property (@(posedge ref_clk) disable iff (!nrst)
      eee_enable && $rose(rx_lpi_s2_r) ##1 eee_enable |-> rx_cnt_r == $past(rx_cnt_r) + 1)
      else $error("rx lpi entry not counted");
   a_eee_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
      !eee_enable |=> rx_cnt_r == 0 && tx_cnt_r == 0 && rx_time_r == 0 && tx_time_r == 0)
      else $error("lpi counters not held at zero");
   a_txoff_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
      !tx_on |=> !jam_r && !pause_r && !zero_r)
      else $error("action with transmitter off");
endmodule

// File: far_side.sv
// pause transmitter and phy management engine standing beside the flow block
`timescale 1ns/1ns
module far_side #(
   parameter logic [15:0] PHY_DATA = 16'h5a3c
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // pause handshake
   input wire logic pause_req,
   input wire logic pause_zero_req,
   input wire logic [3:0] ack_delay,
   output logic pause_ack,
   // phy management engine
   input wire logic mgmt_start,
   output logic mgmt_done,
   output logic [15:0] mgmt_rdata
);
   logic [3:0] wait_r; // cycles waited for a transmit window
   logic [2:0] busy_r; // remaining serial access cycles
   // take a pending pause at the next window, slow when ack_delay is large
   always_ff @(posedge ref_clk)
   begin
      if (!nrst || pause_ack || !(pause_req || pause_zero_req))
      begin
         pause_ack <= 1'b0;
         wait_r <= 4'h0;
      end
      else if (wait_r >= ack_delay)
         pause_ack <= 1'b1;
      else
         wait_r <= wait_r + 4'h1;
   end
   // serial access takes a few cycles
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         busy_r <= 3'h0;
      else if (mgmt_start)
         busy_r <= 3'h5;
      else if (busy_r != 3'h0)
         busy_r <= busy_r - 3'h1;
   end
   assign mgmt_done = (busy_r == 3'h1);
   // data is only good with done, otherwise a moving pattern
   assign mgmt_rdata = mgmt_done ? PHY_DATA : ~PHY_DATA ^ {13'h0, busy_r};
endmodule

// File: tb_top.sv
// self-checking bench for the auto flow control and lpi statistics block
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
   import afc_lpi_pkg::*;
   localparam int USC = 2; // short microsecond for sim
   localparam logic [15:0] PHYD = 16'h5a3c; // arbitrary phy reply
   logic ref_clk = 1'b0; // starts low, so no false edge at time zero
   logic nrst, csr_wr, csr_rd, rx_preamble, rx_da_valid, rx_da_bcast;
   logic rx_da_mcast, rx_da_own, link_100m, jam_active, pause_req, pause_zero_req;
   logic pause_ack, rx_lpi_pin, tx_lpi_req, mgmt_start, mgmt_done, full_duplex;
   logic eee_enable;
   logic [7:0] csr_addr;
   logic [31:0] csr_wdata, csr_rdata, mgmt_access, rd;
   logic [LEVEL_W-1:0] rx_fifo_level;
   logic [15:0] pause_time, mgmt_wdata, mgmt_rdata;
   logic [3:0] ack_delay;
   int n_fail = 0;
   int checks = 0;
   int cyc = 0;
   // device under test
   afc_lpi #(.US_CYCLES(USC)) u_afc_lpi (.ref_clk(ref_clk), .nrst(nrst),
      .csr_addr(csr_addr), .csr_wr(csr_wr), .csr_rd(csr_rd), .csr_wdata(csr_wdata),
      .csr_rdata(csr_rdata), .rx_fifo_level(rx_fifo_level), .rx_preamble(rx_preamble),
      .rx_da_valid(rx_da_valid), .rx_da_bcast(rx_da_bcast), .rx_da_mcast(rx_da_mcast),
      .rx_da_own(rx_da_own), .link_100m(link_100m), .jam_active(jam_active),
      .pause_req(pause_req), .pause_zero_req(pause_zero_req), .pause_ack(pause_ack),
      .pause_time(pause_time), .rx_lpi_pin(rx_lpi_pin), .tx_lpi_req(tx_lpi_req),
      .mgmt_start(mgmt_start), .mgmt_access(mgmt_access), .mgmt_wdata(mgmt_wdata),
      .mgmt_done(mgmt_done), .mgmt_rdata(mgmt_rdata), .full_duplex(full_duplex),
      .eee_enable(eee_enable));
   // far side of the pause and management paths
   far_side #(.PHY_DATA(PHYD)) u_far_side (.ref_clk(ref_clk), .nrst(nrst),
      .pause_req(pause_req), .pause_zero_req(pause_zero_req), .ack_delay(ack_delay),
      .pause_ack(pause_ack), .mgmt_start(mgmt_start), .mgmt_done(mgmt_done),
      .mgmt_rdata(mgmt_rdata));
   // 125 MHz clock
   initial
   begin
      forever #4 ref_clk = ~ref_clk;
   end
   // cut a hang short
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_fail++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // one register write, strobe lowered a cycle later
   task automatic wr_t(input logic [7:0] a, input logic [31:0] d);
      @(negedge ref_clk);
      csr_addr = a;
      csr_wdata = d;
      csr_wr = 1'b1;
      @(negedge ref_clk);
      csr_wr = 1'b0;
   endtask
   // one register read, data valid the cycle after the strobe
   task automatic rd_t(input logic [7:0] a, output logic [31:0] d);
      @(negedge ref_clk);
      csr_addr = a;
      csr_rd = 1'b1;
      @(negedge ref_clk);
      csr_rd = 1'b0;
      d = csr_rdata;
   endtask
   // indirect mac register write and read, waiting out busy
   task automatic mac_wr(input logic [7:0] i, input logic [31:0] v);
      wr_t(OFS_IND_VAL, v);
      wr_t(OFS_IND_CMD, 32'h80000000 | {24'h0, i});
      repeat (2) @(negedge ref_clk);
   endtask
   task automatic mac_rd(input logic [7:0] i, output logic [31:0] v);
      wr_t(OFS_IND_CMD, 32'hc0000000 | {24'h0, i});
      repeat (2) @(negedge ref_clk);
      rd_t(OFS_IND_VAL, v);
   endtask
   task automatic ctrl(input logic fd, input logic eee, input logic txen);
      logic [31:0] v;
      v = CTRL_RESET;
      v[CTRL_FDPX_BIT] = fd;
      v[CTRL_EEE_BIT] = eee;
      v[CTRL_TXEN_BIT] = txen;
      mac_wr(IDX_MAC_CTRL, v);
   endtask
   // expected jam window in cycles from code and line rate
   function automatic int dur_cyc(input logic [3:0] c, input logic fast);
      int t;
      case (c)
         4'h0: t = 50;
         4'h1: t = 100;
         4'h2: t = 150;
         4'h3: t = 250;
         4'h4: t = 500;
         default: t = (int'(c) - 3) * 500;
      endcase
      return t * USC / 10 + (fast ? 0 : EXTRA_10M_NS * USC / US_NS);
   endfunction
   // reset values, read-only and reserved places
   task automatic t_regs();
      logic [7:0] ofs[4] = '{OFS_RX_LPI_CNT, OFS_RX_LPI_TIME, OFS_TX_LPI_CNT, OFS_TX_LPI_TIME};
      logic [7:0] rsv[3] = '{8'h00, 8'h10, 8'hff};
      foreach (ofs[k])
      begin
         wr_t(ofs[k], 32'hffffffff);
         rd_t(ofs[k], rd);
         `CHK(rd, 32'h00000000)
      end
      rd_t(8'h00, rd);
      `CHK(rd, 32'h00000000)
      mac_rd(IDX_MAC_CTRL, rd);
      `CHK(rd, CTRL_RESET)
      mac_wr(IDX_FLOW, 32'h12340000);
      mac_rd(IDX_FLOW, rd);
      `CHK(rd, 32'h12340000)
      `CHK(pause_time, 16'h1234)
      foreach (rsv[k])
      begin
         mac_wr(rsv[k], 32'hffffffff);
         mac_rd(rsv[k], rd);
         `CHK(rd, 32'h00000000)
      end
      wr_t(OFS_AUTO_FLOW_CONFIG, 32'hffffffff);
      rd_t(OFS_AUTO_FLOW_CONFIG, rd);
      `CHK(rd, CFG_USED_MASK)
      $display("test regs done");
   endtask
   // full duplex pause at high level, zero pause below low level
   task automatic t_pause();
      ctrl(1'b1, 1'b0, 1'b1);
      `CHK(full_duplex, 1'b1)
      wr_t(OFS_AUTO_FLOW_CONFIG, {8'h00, 8'h02, 8'h01, 4'h0, 4'hf});
      rx_fifo_level = 14'd127;
      repeat (3) @(negedge ref_clk);
      `CHK(pause_req, 1'b0)
      rx_fifo_level = 14'd128;
      repeat (2) @(negedge ref_clk);
      `CHK(pause_req, 1'b1)
      `CHK(jam_active, 1'b0)
      for (int k = 0; k < 20 && !pause_ack; k++)
         @(negedge ref_clk);
      repeat (2) @(negedge ref_clk);
      `CHK(pause_req, 1'b0)
      rx_fifo_level = 14'd63;
      repeat (3) @(negedge ref_clk);
      `CHK(pause_zero_req, 1'b1)
      for (int k = 0; k < 20 && !pause_ack; k++)
         @(negedge ref_clk);
      repeat (2) @(negedge ref_clk);
      `CHK(pause_zero_req, 1'b0)
      rx_fifo_level = '0;
      $display("test pause done");
   endtask
   // any-frame jam length per duration code, preamble arriving late
   task automatic t_jam_len();
      logic [4:0] cs[7] = '{5'h10, 5'h12, 5'h13, 5'h14, 5'h15, 5'h1f, 5'h01};
      int n;
      int d;
      ctrl(1'b0, 1'b0, 1'b1);
      foreach (cs[k])
      begin
         link_100m = cs[k][4];
         d = dur_cyc(cs[k][3:0], cs[k][4]);
         wr_t(OFS_AUTO_FLOW_CONFIG, {8'h00, 8'h01, 8'h00, cs[k][3:0], 4'h1});
         rx_fifo_level = 14'd64;
         repeat (5) @(negedge ref_clk);
         rx_preamble = 1'b1;
         @(negedge ref_clk);
         rx_preamble = 1'b0;
         `CHK(jam_active, 1'b1)
         n = 6;
         while (jam_active && n < 2000)
         begin
            @(negedge ref_clk);
            n++;
         end
         `CHK(n >= d - 1 && n <= d + 3, 1'b1)
         rx_fifo_level = '0;
         repeat (3) @(negedge ref_clk);
      end
      link_100m = 1'b1;
      $display("test jam length done");
   endtask
   // per-class triggers, duplex and transmitter gating
   task automatic t_class();
      // exp fd txen bc mc own en[3:0]
      logic [9:0] cs[7] = '{10'b1_0_1_100_0100, 10'b1_0_1_001_0010, 10'b0_0_1_010_0100,
         10'b1_0_1_010_1000, 10'b0_1_1_111_1110, 10'b0_0_0_100_0100,
         10'b0_0_1_100_0111};
      foreach (cs[k])
      begin
         ctrl(cs[k][8], 1'b0, cs[k][7]);
         wr_t(OFS_AUTO_FLOW_CONFIG, {8'h00, 8'h01, 8'h00, 4'h0, cs[k][3:0]});
         rx_fifo_level = 14'd64;
         repeat (2) @(negedge ref_clk);
         {rx_da_bcast, rx_da_mcast, rx_da_own} = cs[k][6:4];
         rx_da_valid = 1'b1;
         @(negedge ref_clk);
         rx_da_valid = 1'b0;
         `CHK(jam_active, cs[k][9])
         `CHK(pause_req, 1'b0)
         rx_fifo_level = '0;
         repeat (14) @(negedge ref_clk);
      end
      $display("test class done");
   endtask
   // lpi entry counts and time, cleared with eee off
   task automatic t_lpi();
      logic [31:0] ex[4] = '{32'd1, 32'd10, 32'd2, 32'd20};
      logic [7:0] ofs[4] = '{OFS_RX_LPI_CNT, OFS_RX_LPI_TIME, OFS_TX_LPI_CNT, OFS_TX_LPI_TIME};
      ctrl(1'b0, 1'b1, 1'b1);
      `CHK(eee_enable, 1'b1)
      for (int p = 0; p < 2; p++)
      begin
         rx_lpi_pin = (p == 0);
         tx_lpi_req = 1'b1;
         repeat (10 * USC) @(negedge ref_clk);
         rx_lpi_pin = 1'b0;
         tx_lpi_req = 1'b0;
         repeat (4) @(negedge ref_clk);
      end
      repeat (4) @(negedge ref_clk);
      foreach (ofs[k])
      begin
         rd_t(ofs[k], rd);
         `CHK(rd + 32'd1 >= ex[k] && rd <= ex[k] + 32'd1, 1'b1)
      end
      rd_t(OFS_TX_LPI_CNT, rd);
      `CHK(rd, 32'd2)
      rd_t(OFS_RX_LPI_CNT, rd);
      `CHK(rd, 32'd1)
      ctrl(1'b0, 1'b0, 1'b1);
      foreach (ofs[k])
      begin
         rd_t(ofs[k], rd);
         `CHK(rd, 32'h00000000)
      end
      $display("test lpi done");
   endtask
   // phy management write then read
   task automatic t_phy();
      mac_wr(IDX_PHY_VAL, 32'h0000beef);
      mac_wr(IDX_PHY_ACC, 32'h00000003);
      `CHK(mgmt_wdata, 16'hbeef)
      `CHK(mgmt_access, 32'h00000003)
      repeat (8) @(negedge ref_clk);
      mac_wr(IDX_PHY_ACC, 32'h00000001);
      repeat (8) @(negedge ref_clk);
      mac_rd(IDX_PHY_ACC, rd);
      `CHK(rd[0], 1'b0)
      mac_rd(IDX_PHY_VAL, rd);
      `CHK(rd[15:0], PHYD)
      $display("test phy done");
   endtask
   // main sequence
   initial
   begin
      {nrst, csr_wr, csr_rd, rx_preamble, rx_da_valid, rx_da_bcast} = '0;
      {rx_da_mcast, rx_da_own, rx_lpi_pin, tx_lpi_req} = '0;
      link_100m = 1'b1;
      csr_addr = 8'h00;
      csr_wdata = 32'h0;
      rx_fifo_level = '0;
      ack_delay = 4'h3;
      repeat (4) @(negedge ref_clk);
      nrst = 1'b1;
      t_regs();
      t_pause();
      t_jam_len();
      t_class();
      t_lpi();
      t_phy();
      report_and_stop();
   end
endmodule
